// File: src/tdce_eval.sv
// Tolerant dual-channel evaluation of one pair of safety inputs.
// Inputs A and B come from pins; actuator-enabled and off-delay request
// come from logic on sys_clk. Settings over a plain register port.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Equivalent mode: 00 off, 01 A off, 10 B off, 11 active after good sequence.
// - Complementary mode: 01 off, 00 A off, 11 B off, 10 active after sequence.
// - Outside AND mode, release rises only after both inputs were off since last active.
// - Outside AND mode, active, discrepant, active again is blocked if only one input went off.
// - The two inputs may switch off at different times.
// - After one input switches off the other must follow.
// - Discrepancy time is 0 for infinite or 10 ms to 60 s in 10 ms steps.
// - Discrepancy time bounds how long inputs may disagree before an error.
// - Switch-on and switch-off discrepancy monitoring enable separately.
// - Timeout sets the discrepancy error of the input that did not follow.
// - Fault present sets on any enabled discrepancy timer expiry.
// - All errors clear only when release rises after both inputs were off.
// - AND mode starts on falling actuator-enabled while release is 1.
// - AND mode ends on actuator-enabled 1 or time limit; fault unaffected.
// - AND time limit is 0 for unlimited or 1 to 60000 s in 1 s steps.
// - In AND mode one input off and on again returns to active.
// - In AND mode release drops when any input switches off.
// - In AND mode input B off level still follows input mode.
// - No discrepancy monitoring while AND mode is in effect.
// - Off delay is 0 to 10 s in 10 ms steps.
// - Options enable off-delay input, status outputs and fault output.
// - Complementary mode behaves as equivalent mode with input B inverted.
// - With off-delay request high, release holds through short switch-offs.
// - With request low switch-off acts at once; delay works in both modes.
// - Status outputs show internal input values, including wait and hold; status B is inverted in complementary mode.
module tdce_eval
    import tdce_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic inA,
    input wire logic inB,
    input wire logic actuatorEnabled,
    input wire logic offDelayReq,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic releaseOut,
    output logic discErrA,
    output logic discErrB,
    output logic faultPresent,
    output logic statusA,
    output logic statusB
);

    if (TICK_CYCLES_P < 1 || TICK_CYCLES_P >= (1 << TICK_CNT_W)) begin : g_bad_tick
        $error("TICK_CYCLES_P out of range");
    end

    function automatic logic [22:0] satInc23(input logic [22:0] v);
        satInc23 = (v == 23'h7fffff) ? v : v + 23'h000001;
    endfunction : satInc23

    // Pin synchronisers
    logic [1:0] syncA_q;
    logic [1:0] syncB_q;

    // Settings
    logic [CTRL_W-1:0] ctrl_q;
    logic [12:0] discTime_q;
    logic [15:0] andTime_q;
    logic [9:0] offDelay_q;

    // Tick generator
    logic [TICK_CNT_W-1:0] tickCnt_q;
    logic tick;

    // Evaluation state
    tdce_state_type state_q, state_d;
    logic offA_q, offA_d, offB_q, offB_d;
    logic errA_q, errA_d, errB_q, errB_d, fault_q, fault_d;
    logic onExpired_q, onExpired_d;
    logic andActive_q, andActive_d;
    logic actPrev_q, actPrev_d;
    logic [22:0] discCnt_q, discCnt_d;
    logic [22:0] delayCnt_q, delayCnt_d;
    logic [22:0] andCnt_q, andCnt_d;

    // Output and read-back flops
    logic releaseOut_d, discErrA_d, discErrB_d, faultPresent_d, statusA_d, statusB_d;
    logic [31:0] regRdData_d;

    // Named decode wires
    wire logic isCompl = ctrl_q[CTRL_COMPL];
    wire logic rawA = syncA_q[1];
    wire logic rawB = syncB_q[1] ^ isCompl;
    wire logic holdEn = ctrl_q[CTRL_USE_DLY_IN] && offDelayReq && (state_q == TDCE_ACTIVE);
    wire logic anyRawOff = !rawA || !rawB;
    wire logic hold = holdEn && anyRawOff && (delayCnt_q < 23'(offDelay_q));
    wire logic iA = rawA || hold;
    wire logic iB = rawB || hold;
    wire logic seqDone = offA_q && offB_q;
    wire logic seqOk = seqDone || (andActive_q && (offA_q || offB_q));
    wire logic dirOn = seqDone;
    wire logic monEn = dirOn ? ctrl_q[CTRL_DISC_ON] : ctrl_q[CTRL_DISC_OFF];
    wire logic discExpired = (discTime_q != 13'h0000) && (discCnt_q >= 23'(discTime_q));
    wire logic timeout = (state_q == TDCE_DISC) && !andActive_q && monEn && discExpired;
    wire logic onBlocked = ctrl_q[CTRL_DISC_ON] && onExpired_q;
    wire logic goActive = iA && iB && (state_q != TDCE_ACTIVE) && seqOk && !onBlocked;
    wire logic [22:0] andLimit = 23'(andTime_q) * 23'(TICKS_PER_SEC);
    wire logic andExpired = (andTime_q != 16'h0000) && (andCnt_q >= andLimit);
    wire logic enterAnd = ctrl_q[CTRL_AND_EN] && actPrev_q && !actuatorEnabled
        && (state_q == TDCE_ACTIVE);
    wire logic waitOther = (state_q != TDCE_ACTIVE) && !seqOk;
    wire logic stA = iA && !waitOther;
    wire logic stB = iB && !waitOther;
    wire logic discWrOk = (regWrData[31:13] == 19'h0) && (regWrData[12:0] <= DISC_MAX_TICKS);
    wire logic andWrOk = (regWrData[31:16] == 16'h0) && (regWrData[15:0] <= AND_MAX_SECS);
    wire logic dlyWrOk = (regWrData[31:10] == 22'h0) && (regWrData[9:0] <= OFFDLY_MAX_TICKS);
    wire logic [31:0] statusWord = {25'h0, state_q, andActive_q, fault_q, errB_q, errA_q,
        (state_q == TDCE_ACTIVE)};

    assign tick = (tickCnt_q == TICK_CNT_W'(TICK_CYCLES_P - 1));

    // Evaluation, advanced once per tick
    always_comb begin
        state_d = state_q;
        offA_d = offA_q;
        offB_d = offB_q;
        errA_d = errA_q;
        errB_d = errB_q;
        fault_d = fault_q;
        onExpired_d = onExpired_q;
        andActive_d = andActive_q;
        actPrev_d = actPrev_q;
        discCnt_d = discCnt_q;
        delayCnt_d = delayCnt_q;
        andCnt_d = andCnt_q;
        if (tick) begin
            actPrev_d = actuatorEnabled;
            delayCnt_d = (holdEn && anyRawOff) ? satInc23(delayCnt_q) : 23'h0;
            // State from the internal input pair
            if (!iA && !iB) begin
                state_d = TDCE_DEACT;
            end else if (iA && iB) begin
                if (state_q == TDCE_ACTIVE || goActive) begin
                    state_d = TDCE_ACTIVE;
                end else begin
                    state_d = TDCE_DISC;
                end
            end else begin
                state_d = TDCE_DISC;
            end
            // Off-history, staggered switch-off allowed
            if (goActive) begin
                offA_d = 1'b0;
                offB_d = 1'b0;
            end else begin
                offA_d = offA_q || !iA;
                offB_d = offB_q || !iB;
            end
            discCnt_d = (state_q == TDCE_DISC) ? satInc23(discCnt_q) : 23'h0;
            // Errors: the input that did not follow is flagged
            if (goActive) begin
                errA_d = 1'b0;
                errB_d = 1'b0;
                fault_d = 1'b0;
                onExpired_d = 1'b0;
            end else begin
                if (timeout) begin
                    errA_d = errA_q || (dirOn ? !iA : !offA_q);
                    errB_d = errB_q || (dirOn ? !iB : !offB_q);
                    fault_d = 1'b1;
                    onExpired_d = onExpired_q || dirOn;
                end
                if (!iA && !iB) begin
                    onExpired_d = 1'b0;
                end
            end
            // AND mode
            if (andActive_q) begin
                if (actuatorEnabled || andExpired) begin
                    andActive_d = 1'b0;
                end
                andCnt_d = satInc23(andCnt_q);
            end else begin
                andActive_d = enterAnd;
                andCnt_d = 23'h0;
            end
        end
    end

    // Outputs; fault and status outputs gated by the block options
    assign releaseOut_d = (state_d == TDCE_ACTIVE);
    assign discErrA_d = errA_d;
    assign discErrB_d = errB_d;
    assign faultPresent_d = fault_d && ctrl_q[CTRL_USE_FAULT];
    assign statusA_d = ctrl_q[CTRL_USE_STAT] && stA;
    assign statusB_d = ctrl_q[CTRL_USE_STAT] && (stB ^ isCompl);

    // Read decode; unmapped addresses read zero
    always_comb begin
        regRdData_d = 32'h0;
        if (!regRd) begin
            regRdData_d = 32'h0;
        end else if (regAddr == ADDR_CTRL) begin
            regRdData_d = {25'h0, ctrl_q};
        end else if (regAddr == ADDR_DISC_TIME) begin
            regRdData_d = {19'h0, discTime_q};
        end else if (regAddr == ADDR_AND_TIME) begin
            regRdData_d = {16'h0, andTime_q};
        end else if (regAddr == ADDR_OFF_DELAY) begin
            regRdData_d = {22'h0, offDelay_q};
        end else if (regAddr == ADDR_STATUS) begin
            regRdData_d = statusWord;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            syncA_q <= 2'h0;
            syncB_q <= 2'h0;
        end else begin
            syncA_q <= {syncA_q[0], inA};
            syncB_q <= {syncB_q[0], inB};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tickCnt_q <= '0;
        end else if (tick) begin
            tickCnt_q <= '0;
        end else begin
            tickCnt_q <= tickCnt_q + TICK_CNT_W'(1);
        end
    end

    // Settings; out-of-range time values are ignored
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            discTime_q <= DISC_RESET;
            andTime_q <= AND_RESET;
            offDelay_q <= OFFDLY_RESET;
        end else if (regWr) begin
            if (regAddr == ADDR_CTRL) begin
                ctrl_q <= regWrData[CTRL_W-1:0];
            end else if (regAddr == ADDR_DISC_TIME && discWrOk) begin
                discTime_q <= regWrData[12:0];
            end else if (regAddr == ADDR_AND_TIME && andWrOk) begin
                andTime_q <= regWrData[15:0];
            end else if (regAddr == ADDR_OFF_DELAY && dlyWrOk) begin
                offDelay_q <= regWrData[9:0];
            end
        end
    end

    // Evaluation state and off history
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= TDCE_DEACT;
            offA_q <= 1'b0;
            offB_q <= 1'b0;
        end else begin
            state_q <= state_d;
            offA_q <= offA_d;
            offB_q <= offB_d;
        end
    end

    // Error flags, held until release rises
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            errA_q <= 1'b0;
            errB_q <= 1'b0;
            fault_q <= 1'b0;
            onExpired_q <= 1'b0;
        end else begin
            errA_q <= errA_d;
            errB_q <= errB_d;
            fault_q <= fault_d;
            onExpired_q <= onExpired_d;
        end
    end

    // AND mode tracking
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            andActive_q <= 1'b0;
            actPrev_q <= 1'b0;
            andCnt_q <= 23'h0;
        end else begin
            andActive_q <= andActive_d;
            actPrev_q <= actPrev_d;
            andCnt_q <= andCnt_d;
        end
    end

    // Discrepancy and off-delay timers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            discCnt_q <= 23'h0;
            delayCnt_q <= 23'h0;
        end else begin
            discCnt_q <= discCnt_d;
            delayCnt_q <= delayCnt_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            releaseOut <= 1'b0;
            discErrA <= 1'b0;
            discErrB <= 1'b0;
            faultPresent <= 1'b0;
            statusA <= 1'b0;
            statusB <= 1'b0;
        end else begin
            releaseOut <= releaseOut_d;
            discErrA <= discErrA_d;
            discErrB <= discErrB_d;
            faultPresent <= faultPresent_d;
            statusA <= statusA_d;
            statusB <= statusB_d;
        end
    end

    // Read data stands for the one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regRdData <= 32'h0;
        end else begin
            regRdData <= regRdData_d;
        end
    end

endmodule : tdce_eval

`default_nettype wire

// File: src/tdce_pkg.sv
// Package of the tolerant dual-channel evaluation block.
// Holds register offsets, field positions, reset values and timing counts.
package tdce_pkg;

    // Clock and evaluation tick
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_PERIOD_MS = 10;
    localparam int unsigned TICK_CYCLES =
        (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned TICKS_PER_SEC = 1000 / TICK_PERIOD_MS;
    localparam int unsigned TICK_CNT_W = 21;

    // Setting limits, in their own units
    localparam int unsigned DISC_MAX_MS = 60000;
    localparam int unsigned AND_MAX_S = 60000;
    localparam int unsigned OFFDLY_MAX_MS = 10000;
    localparam logic [12:0] DISC_MAX_TICKS = 13'(DISC_MAX_MS / TICK_PERIOD_MS);
    localparam logic [15:0] AND_MAX_SECS = 16'(AND_MAX_S);
    localparam logic [9:0] OFFDLY_MAX_TICKS = 10'(OFFDLY_MAX_MS / TICK_PERIOD_MS);

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DISC_TIME = 8'h04;
    localparam logic [7:0] ADDR_AND_TIME = 8'h08;
    localparam logic [7:0] ADDR_OFF_DELAY = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Control register fields
    localparam int unsigned CTRL_COMPL = 0;
    localparam int unsigned CTRL_AND_EN = 1;
    localparam int unsigned CTRL_DISC_ON = 2;
    localparam int unsigned CTRL_DISC_OFF = 3;
    localparam int unsigned CTRL_USE_DLY_IN = 4;
    localparam int unsigned CTRL_USE_STAT = 5;
    localparam int unsigned CTRL_USE_FAULT = 6;
    localparam int unsigned CTRL_W = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    // Status register fields
    localparam int unsigned STAT_RELEASE = 0;
    localparam int unsigned STAT_ERR_A = 1;
    localparam int unsigned STAT_ERR_B = 2;
    localparam int unsigned STAT_FAULT = 3;
    localparam int unsigned STAT_AND = 4;
    localparam int unsigned STAT_STATE = 5;

    // Reset values of the time settings
    localparam logic [12:0] DISC_RESET = 13'h0000;
    localparam logic [15:0] AND_RESET = 16'h0000;
    localparam logic [9:0] OFFDLY_RESET = 10'h000;

    // Evaluation states, Gray coded along deactivated, discrepant, active
    typedef enum logic [1:0] {
        TDCE_DEACT = 2'h0,
        TDCE_DISC = 2'h1,
        TDCE_ACTIVE = 2'h3
    } tdce_state_type;

endpackage : tdce_pkg

// File: verif/tdce_eval_asserts.sv
// Port checker of the tolerant dual-channel evaluation block.
// Assumes a bind onto tdce_eval with the same tick count.
`timescale 1ns/1ns
`default_nettype none
module tdce_eval_chk
    import tdce_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic inA,
    input wire logic inB,
    input wire logic actuatorEnabled,
    input wire logic offDelayReq,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic releaseOut,
    input wire logic discErrA,
    input wire logic discErrB,
    input wire logic faultPresent,
    input wire logic statusA,
    input wire logic statusB
);
    logic relPrev_q;
    logic [7:0] sinceChg_q;
    logic [7:0] aOff_q;
    // Cycles since release last moved, and since input A was last seen on or off-delay request high
    always_ff @(posedge sys_clk) begin
        relPrev_q <= releaseOut;
        if (!rst_n || releaseOut != relPrev_q) sinceChg_q <= 8'h00;
        else if (sinceChg_q != 8'hff) sinceChg_q <= sinceChg_q + 8'h01;
        if (!rst_n || inA || offDelayReq) aOff_q <= 8'h00;
        else if (aOff_q != 8'hff) aOff_q <= aOff_q + 8'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence ctrlWrThenRd;
        regWr && regAddr == ADDR_CTRL ##1 regRd && regAddr == ADDR_CTRL;
    endsequence
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data not zero outside a read");
    AST_RD_UNMAP: assert property ($past(regRd) && $past(regAddr) > ADDR_STATUS
        |-> regRdData == 32'h0) else $error("unmapped read not zero");
    AST_CTRL_RB: assert property (ctrlWrThenRd |=>
        regRdData == ($past(regWrData, 2) & 32'h7f)) else $error("control readback");
    AST_ERR_CLR: assert property ($rose(releaseOut)
        |-> !discErrA && !discErrB && !faultPresent) else $error("errors kept");
    AST_ERR_HOLD: assert property ($fell(discErrA) || $fell(discErrB)
        |-> $rose(releaseOut)) else $error("error cleared without release");
    AST_FAULT_SRC: assert property ($rose(faultPresent)
        |-> discErrA || discErrB) else $error("fault without timeout");
    AST_ERR_OFF_REL: assert property ($rose(discErrA) || $rose(discErrB)
        |-> !releaseOut) else $error("timeout while released");
    AST_ONE_TICK: assert property (releaseOut != relPrev_q
        |-> sinceChg_q >= TICK_CYCLES_P - 1) else $error("release moved between ticks");
    AST_A_OFF_DROP: assert property (aOff_q >= TICK_CYCLES_P + 5
        |-> !releaseOut) else $error("release kept with input A off");
endmodule : tdce_eval_chk
`default_nettype wire

// File: verif/tdce_switch_model.sv
// Pair of dual-channel safety contacts on the evaluation inputs.
// Assumes the bench sets the wanted contact states between clock edges.
`timescale 1ns/1ns
`default_nettype none
module tdce_switch_model (
    input wire logic sys_clk,
    input wire logic wantA,
    input wire logic wantB,
    input wire logic compl,
    output logic inA,
    output logic inB
);
    always @(posedge sys_clk) begin
        inA <= wantA;
        inB <= wantB ^ compl;
    end
endmodule : tdce_switch_model
`default_nettype wire

// File: verif/tdce_eval_tb.sv
// Self-checking bench of the tolerant dual-channel evaluation block.
// Assumes a short tick so that every sequence stays brief.
`timescale 1ns/1ns
`default_nettype none
module tdce_eval_tb;
    import tdce_pkg::*;
    localparam int unsigned TK = 8;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wantA = 1'b0, wantB = 1'b0, compl = 1'b0, inA, inB;
    logic actuatorEnabled = 1'b0, offDelayReq = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, d;
    logic regWr = 1'b0, regRd = 1'b0;
    logic releaseOut, discErrA, discErrB, faultPresent, statusA, statusB;
    int failures = 0;
    int checks = 0;
    always #4 sys_clk = ~sys_clk;
    tdce_switch_model sw_u (.sys_clk(sys_clk), .wantA(wantA), .wantB(wantB),
        .compl(compl), .inA(inA), .inB(inB));
    tdce_eval #(.TICK_CYCLES_P(TK)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .inA(inA),
        .inB(inB), .actuatorEnabled(actuatorEnabled), .offDelayReq(offDelayReq),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .releaseOut(releaseOut), .discErrA(discErrA),
        .discErrB(discErrB), .faultPresent(faultPresent), .statusA(statusA),
        .statusB(statusB));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n * TK) @(posedge sys_clk);
        #1;
    endtask : wt
    task automatic sw(input logic a, input logic b, input int n);
        wantA <= a;
        wantB <= b;
        wt(n);
    endtask : sw
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask : rd
    // Control write followed at once by its readback
    task automatic cfg(input logic [31:0] c);
        @(posedge sys_clk);
        regAddr <= ADDR_CTRL;
        regWrData <= c;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 chk("ctrl", regRdData, c);
        compl = c[CTRL_COMPL];
    endtask : cfg
    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(ADDR_STATUS);
        chk("status", d, 32'h0);
        rd(8'h40);
        chk("unmapped", d, 32'h0);
        wr(ADDR_DISC_TIME, 32'h1770);
        wr(ADDR_DISC_TIME, 32'h1771);
        rd(ADDR_DISC_TIME);
        chk("disc", d, 32'h1770);
        wr(ADDR_DISC_TIME, 32'h3);
        cfg(32'h0);
        sw(1'b0, 1'b0, 3);
        sw(1'b1, 1'b1, 3);
        chk("rel", releaseOut, 32'h1);
        sw(1'b0, 1'b1, 3);
        chk("rel", releaseOut, 32'h0);
        sw(1'b1, 1'b1, 3);
        chk("rel", releaseOut, 32'h0);
        sw(1'b1, 1'b0, 3);
        sw(1'b1, 1'b1, 3);
        chk("rel", releaseOut, 32'h1);
        cfg(32'h44);
        sw(1'b0, 1'b0, 3);
        sw(1'b1, 1'b0, 6);
        chk("errB", discErrB, 32'h1);
        chk("errA", discErrA, 32'h0);
        chk("fault", faultPresent, 32'h1);
        sw(1'b1, 1'b1, 3);
        chk("rel", releaseOut, 32'h0);
        sw(1'b0, 1'b0, 3);
        sw(1'b1, 1'b1, 3);
        chk("rel", releaseOut, 32'h1);
        chk("errB", discErrB, 32'h0);
        chk("fault", faultPresent, 32'h0);
        sw(1'b0, 1'b1, 6);
        chk("errB", discErrB, 32'h0);
        cfg(32'h48);
        sw(1'b0, 1'b0, 3);
        sw(1'b1, 1'b1, 3);
        sw(1'b1, 1'b0, 6);
        chk("errA", discErrA, 32'h1);
        sw(1'b0, 1'b0, 3);
        sw(1'b1, 1'b1, 3);
        chk("errA", discErrA, 32'h0);
        cfg(32'h1);
        sw(1'b0, 1'b0, 3);
        sw(1'b1, 1'b1, 3);
        chk("rel", releaseOut, 32'h1);
        sw(1'b1, 1'b0, 3);
        chk("rel", releaseOut, 32'h0);
        cfg(32'h4a);
        actuatorEnabled <= 1'b1;
        sw(1'b0, 1'b0, 3);
        sw(1'b1, 1'b1, 3);
        actuatorEnabled <= 1'b0;
        wt(3);
        rd(ADDR_STATUS);
        chk("and", d[STAT_AND], 32'h1);
        sw(1'b0, 1'b1, 6);
        chk("rel", releaseOut, 32'h0);
        chk("errB", discErrB, 32'h0);
        chk("fault", faultPresent, 32'h0);
        sw(1'b1, 1'b1, 3);
        chk("rel", releaseOut, 32'h1);
        actuatorEnabled <= 1'b1;
        wt(3);
        rd(ADDR_STATUS);
        chk("and", d[STAT_AND], 32'h0);
        wr(ADDR_AND_TIME, 32'h1);
        actuatorEnabled <= 1'b0;
        wt(3);
        rd(ADDR_STATUS);
        chk("and", d[STAT_AND], 32'h1);
        wt(100);
        rd(ADDR_STATUS);
        chk("and", d[STAT_AND], 32'h0);
        chk("fault", faultPresent, 32'h0);
        cfg(32'h30);
        wr(ADDR_OFF_DELAY, 32'h4);
        offDelayReq <= 1'b1;
        sw(1'b0, 1'b1, 1);
        chk("rel", releaseOut, 32'h1);
        sw(1'b1, 1'b1, 3);
        chk("rel", releaseOut, 32'h1);
        chk("statA", statusA, 32'h1);
        chk("statB", statusB, 32'h1);
        sw(1'b0, 1'b1, 8);
        chk("rel", releaseOut, 32'h0);
        chk("statA", statusA, 32'h0);
        chk("statB", statusB, 32'h0);
        sw(1'b0, 1'b0, 3);
        sw(1'b1, 1'b1, 3);
        offDelayReq <= 1'b0;
        sw(1'b0, 1'b1, 2);
        chk("rel", releaseOut, 32'h0);
        tally_and_finish();
    end
endmodule : tdce_eval_tb
bind tdce_eval tdce_eval_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) chk_u (.sys_clk(sys_clk),
    .rst_n(rst_n), .inA(inA), .inB(inB), .actuatorEnabled(actuatorEnabled),
    .offDelayReq(offDelayReq), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .releaseOut(releaseOut), .discErrA(discErrA),
    .discErrB(discErrB), .faultPresent(faultPresent), .statusA(statusA),
    .statusB(statusB));
`default_nettype wire
